// ===== rtl/mns_pkg.sv
`default_nettype none
package mns_pkg;
  // instruction cycle phases, one-hot
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } mns_phase_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_MULL = 3'h1,
    OP_MULF = 3'h2,
    OP_NEG  = 3'h3,
    OP_MOV  = 3'h4,
    OP_PUSH = 3'h5,
    OP_POP  = 3'h6
  } mns_op_e;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } mns_instr_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mns_bus_s;

  // opcode patterns
  localparam logic [7:0]  ENC_MULL  = 8'h0D;
  localparam logic [6:0]  ENC_MULF  = 7'h01;
  localparam logic [6:0]  ENC_NEG   = 7'h36;
  localparam logic [6:0]  ENC_MOV   = 7'h37;
  localparam logic [15:0] ENC_PUSH  = 16'h0005;
  localparam logic [15:0] ENC_POP   = 16'h0006;
  localparam logic [7:0]  IDX_LIMIT = 8'h5F;
  localparam logic [7:0]  ACC_SPLIT = 8'h60;
  localparam logic [3:0]  ACC_HIGH  = 4'hF;

  // register offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ACC   = 8'h01;
  localparam logic [7:0] REG_BANK  = 8'h02;
  localparam logic [7:0] REG_STAT  = 8'h03;
  localparam logic [7:0] REG_PLO   = 8'h04;
  localparam logic [7:0] REG_PHI   = 8'h05;
  localparam logic [7:0] REG_TOSL  = 8'h06;
  localparam logic [7:0] REG_TOSH  = 8'h07;
  localparam logic [7:0] REG_TOSU  = 8'h08;
  localparam logic [7:0] REG_SPTR  = 8'h09;
  localparam logic [7:0] REG_IDXL  = 8'h0A;
  localparam logic [7:0] REG_IDXH  = 8'h0B;
  localparam logic [7:0] REG_MADL  = 8'h0C;
  localparam logic [7:0] REG_MADH  = 8'h0D;
  localparam logic [7:0] REG_MDAT  = 8'h0E;

  // status bit positions
  localparam int ST_C  = 0;
  localparam int ST_HC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_SX = 3;
  localparam int ST_N  = 4;

  localparam int STK_DEPTH = 31;
  localparam int PC_W      = 21;
  localparam int MEM_DEPTH = 4096;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
endpackage
`default_nettype wire

// ===== rtl/mns_exec.sv
// Overview of operation
// [RL1] access bit 0 access bank, 1 bank select
// [RL2] extended mode: a=0, f<=95 is indexed
// [RL3] move copies accumulator to file, flags kept
// [RL4] literal multiply: 16-bit product, accumulator kept
// [RL5] multiplies never touch any status flag
// [RL6] register multiply: product pair, operands kept
// [RL7] negate writes two's complement back
// [RL8] negate updates all five status flags
// [RL9] pop discards top in third phase
// [RL10] push stores pc plus two in second phase
// [RL11] software may write top of stack
// [RL12] zero word or 1111 prefix is nop
// [RL13] read Q2, compute Q3, write Q4
//
// Our own choices: the placing of the registers and strobed register access.
`default_nettype none
module mns_exec
  import mns_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire mns_instr_s      instr,
  input  wire logic [PC_W-1:0] pc,
  input  wire mns_bus_s        bus,
  output logic [7:0]           rd_data_q,
  output mns_phase_e           phase_q,
  output logic                 done_q
);

  logic [7:0]       acc_q;
  logic [3:0]       bank_q;
  logic [4:0]       stat_q;
  logic [7:0]       prod_lo_q;
  logic [7:0]       prod_hi_q;
  logic             ext_en_q;
  logic [11:0]      idx_q;
  logic [11:0]      madr_q;
  logic [7:0]       mem_q [MEM_DEPTH];
  logic [PC_W-1:0]  stk_q [STK_DEPTH+1];
  logic [4:0]       sptr_q;
  mns_op_e          op_q;
  mns_op_e          op_d;
  logic [11:0]      faddr_q;
  logic [11:0]      faddr_d;
  logic             abit_q;
  logic [7:0]       lit_q;
  logic [7:0]       opnd_q;
  logic [15:0]      prod_q;
  logic [7:0]       neg_q;
  logic [4:0]       nflag_q;
  logic [8:0]       neg_sum;
  logic [4:0]       neg_nib;
  ////////////////////////////////////////////////////////////////////////
  // phase sequencer, free running
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q <= PH_Q1;
    end else begin
      case (phase_q)
        PH_Q1:   phase_q <= PH_Q2;
        PH_Q2:   phase_q <= PH_Q3;
        PH_Q3:   phase_q <= PH_Q4;
        default: phase_q <= PH_Q1;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // decode
  // [RL12] nop decode default
  always_comb begin
    op_d = OP_NONE;
    if (instr.valid) begin
      if (instr.word[15:8] == ENC_MULL) begin
        op_d = OP_MULL;
      end else if (instr.word[15:9] == ENC_MULF) begin
        op_d = OP_MULF;
      end else if (instr.word[15:9] == ENC_NEG) begin
        op_d = OP_NEG;
      end else if (instr.word[15:9] == ENC_MOV) begin
        op_d = OP_MOV;
      end else if (instr.word == ENC_PUSH) begin
        op_d = OP_PUSH;
      end else if (instr.word == ENC_POP) begin
        op_d = OP_POP;
      end
    end
  end

  // [RL1] [RL2] operand address
  always_comb begin
    if (instr.word[8]) begin
      faddr_d = {bank_q, instr.word[7:0]};
    end else if (ext_en_q && instr.word[7:0] <= IDX_LIMIT) begin
      faddr_d = idx_q + {4'h0, instr.word[7:0]};
    end else if (instr.word[7:0] < ACC_SPLIT) begin
      faddr_d = {4'h0, instr.word[7:0]};
    end else begin
      faddr_d = {ACC_HIGH, instr.word[7:0]};
    end
  end

  // [RL13] decode in Q1
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_q    <= OP_NONE;
      faddr_q <= 12'h000;
      abit_q  <= 1'b0;
      lit_q   <= 8'h00;
    end else if (phase_q == PH_Q1) begin
      op_q    <= op_d;
      faddr_q <= faddr_d;
      abit_q  <= instr.word[8];
      lit_q   <= instr.word[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // operand read and compute
  assign neg_sum = {1'b0, ~opnd_q} + 9'h001;
  assign neg_nib = {1'b0, ~opnd_q[3:0]} + 5'h01;

  // [RL13] read Q2, compute Q3
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opnd_q  <= 8'h00;
      prod_q  <= 16'h0000;
      neg_q   <= 8'h00;
      nflag_q <= 5'h00;
    end else if (phase_q == PH_Q2) begin
      opnd_q <= (op_q == OP_MULL) ? lit_q : mem_q[faddr_q];
    end else if (phase_q == PH_Q3) begin
      prod_q <= {8'h00, acc_q} * {8'h00, opnd_q};
      neg_q  <= neg_sum[7:0];
      // [RL8] negate flags
      nflag_q[ST_C]  <= neg_sum[8];
      nflag_q[ST_HC] <= neg_nib[4];
      nflag_q[ST_Z]  <= (neg_sum[7:0] == 8'h00);
      nflag_q[ST_SX] <= (opnd_q == 8'h80);
      nflag_q[ST_N]  <= neg_sum[7];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // file memory; instruction write beats a same-cycle software write
  always_ff @(posedge clk) begin
    if (phase_q == PH_Q4 && op_q == OP_MOV) begin
      // [RL3] accumulator to file
      mem_q[faddr_q] <= acc_q;
    end else if (phase_q == PH_Q4 && op_q == OP_NEG) begin
      // [RL7] negate write back
      mem_q[faddr_q] <= neg_q;
    end else if (bus.wr && bus.addr == REG_MDAT) begin
      mem_q[madr_q] <= bus.wdata;
    end
  end

  // [RL4] [RL6] product pair write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prod_lo_q <= 8'h00;
      prod_hi_q <= 8'h00;
    end else if (phase_q == PH_Q4 && (op_q == OP_MULL || op_q == OP_MULF)) begin
      prod_lo_q <= prod_q[7:0];
      prod_hi_q <= prod_q[15:8];
    end else if (bus.wr && bus.addr == REG_PLO) begin
      prod_lo_q <= bus.wdata;
    end else if (bus.wr && bus.addr == REG_PHI) begin
      prod_hi_q <= bus.wdata;
    end
  end

  // [RL5] only negate and software writes touch status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_q <= 5'h00;
    end else if (phase_q == PH_Q4 && op_q == OP_NEG) begin
      stat_q <= nflag_q;
    end else if (bus.wr && bus.addr == REG_STAT) begin
      stat_q <= bus.wdata[4:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q    <= 8'h00;
      bank_q   <= 4'h0;
      ext_en_q <= 1'b0;
      idx_q    <= 12'h000;
      madr_q   <= 12'h000;
    end else if (bus.wr) begin
      if (bus.addr == REG_ACC) begin
        acc_q <= bus.wdata;
      end else if (bus.addr == REG_BANK) begin
        bank_q <= bus.wdata[3:0];
      end else if (bus.addr == REG_CTRL) begin
        ext_en_q <= bus.wdata[0];
      end else if (bus.addr == REG_IDXL) begin
        idx_q[7:0] <= bus.wdata;
      end else if (bus.addr == REG_IDXH) begin
        idx_q[11:8] <= bus.wdata[3:0];
      end else if (bus.addr == REG_MADL) begin
        madr_q[7:0] <= bus.wdata;
      end else if (bus.addr == REG_MADH) begin
        madr_q[11:8] <= bus.wdata[3:0];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // return stack; slot 0 is the empty marker, full stack ignores push
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sptr_q <= 5'h00;
    end else if (phase_q == PH_Q2 && op_q == OP_PUSH && sptr_q != 5'(STK_DEPTH)) begin
      // [RL10] push pointer
      sptr_q <= sptr_q + 5'h01;
    end else if (phase_q == PH_Q3 && op_q == OP_POP && sptr_q != 5'h00) begin
      // [RL9] pop discards top
      sptr_q <= sptr_q - 5'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (phase_q == PH_Q2 && op_q == OP_PUSH && sptr_q != 5'(STK_DEPTH)) begin
      // [RL10] pc plus two on top
      stk_q[sptr_q + 5'h01] <= pc + PC_STEP;
    end else if (bus.wr && bus.addr == REG_TOSL) begin
      // [RL11] software edits top
      stk_q[sptr_q][7:0] <= bus.wdata;
    end else if (bus.wr && bus.addr == REG_TOSH) begin
      stk_q[sptr_q][15:8] <= bus.wdata;
    end else if (bus.wr && bus.addr == REG_TOSU) begin
      stk_q[sptr_q][20:16] <= bus.wdata[4:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // read port and completion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_q <= 8'h00;
    end else if (!bus.rd) begin
      rd_data_q <= 8'h00;
    end else if (bus.addr == REG_CTRL) begin
      rd_data_q <= {7'h00, ext_en_q};
    end else if (bus.addr == REG_ACC) begin
      rd_data_q <= acc_q;
    end else if (bus.addr == REG_BANK) begin
      rd_data_q <= {4'h0, bank_q};
    end else if (bus.addr == REG_STAT) begin
      rd_data_q <= {3'h0, stat_q};
    end else if (bus.addr == REG_PLO) begin
      rd_data_q <= prod_lo_q;
    end else if (bus.addr == REG_PHI) begin
      rd_data_q <= prod_hi_q;
    end else if (bus.addr == REG_TOSL) begin
      rd_data_q <= stk_q[sptr_q][7:0];
    end else if (bus.addr == REG_TOSH) begin
      rd_data_q <= stk_q[sptr_q][15:8];
    end else if (bus.addr == REG_TOSU) begin
      rd_data_q <= {3'h0, stk_q[sptr_q][20:16]};
    end else if (bus.addr == REG_SPTR) begin
      rd_data_q <= {3'h0, sptr_q};
    end else if (bus.addr == REG_IDXL) begin
      rd_data_q <= idx_q[7:0];
    end else if (bus.addr == REG_IDXH) begin
      rd_data_q <= {4'h0, idx_q[11:8]};
    end else if (bus.addr == REG_MADL) begin
      rd_data_q <= madr_q[7:0];
    end else if (bus.addr == REG_MADH) begin
      rd_data_q <= {4'h0, madr_q[11:8]};
    end else if (bus.addr == REG_MDAT) begin
      rd_data_q <= mem_q[madr_q];
    end else begin
      rd_data_q <= 8'h00;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (phase_q == PH_Q4);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking dclk @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_bank;  // [RL1]
    (phase_q == PH_Q2 && abit_q && op_q inside {OP_MULF, OP_NEG, OP_MOV}) |-> faddr_q[11:8] == $past(bank_q);
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");  // [RL1]
  property p_index;  // [RL2]
    (phase_q == PH_Q1 && instr.valid && !instr.word[8] && ext_en_q && instr.word[7:0] <= IDX_LIMIT)
      |=> faddr_q == $past(idx_q) + {4'h0, lit_q};
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");  // [RL2]
  property p_mov;  // [RL3]
    (phase_q == PH_Q4 && op_q == OP_MOV) |=> mem_q[$past(faddr_q)] == $past(acc_q) && $stable(stat_q);
  endproperty
  a_mov: assert property (p_mov) else $error("move result wrong");  // [RL3]
  property p_mull;  // [RL4]
    (phase_q == PH_Q1 && op_d == OP_MULL && !bus.wr) ##3 1'b1
      |=> {prod_hi_q, prod_lo_q} == {8'h00, $past(acc_q, 2)} * {8'h00, $past(lit_q, 3)};
  endproperty
  a_mull: assert property (p_mull) else $error("literal product wrong");  // [RL4]
  property p_mul_flags;  // [RL5]
    (phase_q == PH_Q4 && op_q inside {OP_MULL, OP_MULF}) |=> stat_q == $past(stat_q);
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("multiply changed flags");  // [RL5]
  property p_mulf;  // [RL6]
    (phase_q == PH_Q4 && op_q == OP_MULF)
      |=> {prod_hi_q, prod_lo_q} == {8'h00, $past(acc_q, 2)} * {8'h00, mem_q[$past(faddr_q)]} && $stable(acc_q);
  endproperty
  a_mulf: assert property (p_mulf) else $error("register product wrong");  // [RL6]
  property p_neg;  // [RL7]
    (phase_q == PH_Q2 && op_q == OP_NEG) ##2 1'b1 |=> mem_q[$past(faddr_q)] == 8'(8'h00 - $past(opnd_q, 2));
  endproperty
  a_neg: assert property (p_neg) else $error("negate result wrong");  // [RL7]
  property p_neg_flags;  // [RL8]
    (phase_q == PH_Q4 && op_q == OP_NEG)
      |=> stat_q[ST_Z] == ($past(opnd_q) == 8'h00) && stat_q[ST_SX] == ($past(opnd_q) == 8'h80);
  endproperty
  a_neg_flags: assert property (p_neg_flags) else $error("negate flags wrong");  // [RL8]
  property p_pop;  // [RL9]
    (phase_q == PH_Q3 && op_q == OP_POP && sptr_q != 5'h00) |=> sptr_q == $past(sptr_q) - 5'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop pointer wrong");  // [RL9]
  property p_push;  // [RL10]
    (phase_q == PH_Q2 && op_q == OP_PUSH && sptr_q != 5'(STK_DEPTH)) |=> stk_q[sptr_q] == $past(pc) + PC_STEP;
  endproperty
  a_push: assert property (p_push) else $error("push value wrong");  // [RL10]
  property p_nop;  // [RL12]
    (phase_q == PH_Q4 && op_q == OP_NONE && !bus.wr)
      |=> $stable(stat_q) && $stable(sptr_q) && $stable(prod_lo_q) && $stable(prod_hi_q);
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state");  // [RL12]
  c_mull: cover property (phase_q == PH_Q4 && op_q == OP_MULL);
  c_neg0: cover property (phase_q == PH_Q4 && op_q == OP_NEG && opnd_q == 8'h00);
  c_push: cover property (phase_q == PH_Q2 && op_q == OP_PUSH);
  c_pop:  cover property (phase_q == PH_Q3 && op_q == OP_POP && sptr_q != 5'h00);
endmodule
`default_nettype wire

// ===== tb/tb_mns_exec.sv
`default_nettype none
module tb_mns_exec
  import mns_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk;
  logic            rst_n;
  mns_instr_s      instr;
  logic [PC_W-1:0] pc;
  mns_bus_s        bus;
  logic [7:0]      rd_data_q;
  mns_phase_e      phase_q;
  logic            done_q;
  int              bad_count;
  int              check_count;
  logic [7:0]      exp_q[$];
  logic            rd_prev;
  logic [31:0]     seed;

  mns_exec dut_u (
    .clk       (clk),
    .rst_n     (rst_n),
    .instr     (instr),
    .pc        (pc),
    .bus       (bus),
    .rd_data_q (rd_data_q),
    .phase_q   (phase_q),
    .done_q    (done_q)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic void rnd(output logic [7:0] v);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    v = seed[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////
  // one idle cycle between strobes keeps every driver edge distinct
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic set_ma(input logic [11:0] a);
    wr(REG_MADL, a[7:0]);
    wr(REG_MADH, {4'h0, a[11:8]});
  endtask

  task automatic wmem(input logic [11:0] a, input logic [7:0] d);
    set_ma(a);
    wr(REG_MDAT, d);
  endtask

  task automatic rmem(input logic [11:0] a, input logic [7:0] e);
    set_ma(a);
    rd(REG_MDAT, e);
  endtask

  // instr held until the q1 edge takes it; ignored in q2..q4 anyway
  task automatic exe(input logic v, input logic [15:0] w, input logic [PC_W-1:0] p);
    int n;
    @(posedge clk);
    instr <= '{valid: v, word: w};
    pc    <= p;
    for (n = 1; n <= 8; n++) begin
      @(negedge clk);
      if (phase_q === PH_Q1) break;
    end
    check("q1 wait", 16'(n > 8), 16'h0000);
    @(posedge clk);
    instr <= '0;
    for (n = 1; n <= 8; n++) begin
      @(negedge clk);
      if (done_q === 1'b1) break;
    end
    check("done delay", 16'(n), 16'h0004);
    if (n > 8) end_of_test();
  endtask

  ////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_prev <= bus.rd;

  always @(negedge clk) begin
    if (rd_prev) begin
      if (exp_q.size() == 0) check("read queue", 16'h0001, 16'h0000);
      else check("rd_data_q", {8'h00, rd_data_q}, {8'h00, exp_q.pop_front()});
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0]  a;
    logic [7:0]  k;
    logic [7:0]  f;
    logic [7:0]  s;
    logic [7:0]  r;
    logic [15:0] prod;
    logic [7:0]  regs[7];
    logic [7:0]  negs[4];
    bad_count   = 0;
    check_count = 0;
    seed        = 32'h0001_3E0D;
    rst_n       = 1'b0;
    instr       = '0;
    pc          = '0;
    bus         = '0;
    regs = '{REG_CTRL, REG_ACC, REG_BANK, REG_STAT, REG_PLO, REG_PHI, REG_SPTR};
    negs = '{8'h3A, 8'h00, 8'h80, 8'h01};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("phase after reset", {12'h000, phase_q}, {12'h000, PH_Q1});
    foreach (regs[i]) rd(regs[i], 8'h00);
    wr(8'h3F, 8'hA5);
    rd(8'h3F, 8'h00);
    rnd(a);
    rnd(f);
    rnd(s);
    s = {3'h0, s[4:0]};
    wr(REG_ACC, a);
    wr(REG_BANK, 8'h03);
    wr(REG_STAT, s);
    exe(1'b1, {ENC_MOV, 1'b1, f}, '0);
    rmem({4'h3, f}, a);
    exe(1'b1, {ENC_MOV, 1'b0, 8'h10}, '0);
    rmem(12'h010, a);
    exe(1'b1, {ENC_MOV, 1'b0, 8'hA0}, '0);
    rmem(12'hFA0, a);
    rd(REG_STAT, s);
    wr(REG_BANK, 8'h05);
    for (int i = 0; i < 5; i++) begin
      rnd(a);
      rnd(k);
      rnd(f);
      if (i == 0) begin
        a = 8'hE2;
        k = 8'hC4;
      end
      if (i == 1) k = 8'h00;
      if (i == 2) begin
        a = 8'hFF;
        k = 8'hFF;
      end
      prod = a * k;
      wr(REG_ACC, a);
      exe(1'b1, {ENC_MULL, k}, '0);
      rd(REG_PLO, prod[7:0]);
      rd(REG_PHI, prod[15:8]);
      rd(REG_ACC, a);
      rnd(k);
      prod = a * k;
      wmem({4'h5, f}, k);
      exe(1'b1, {ENC_MULF, 1'b1, f}, '0);
      rd(REG_PLO, prod[7:0]);
      rd(REG_PHI, prod[15:8]);
      rmem({4'h5, f}, k);
      rd(REG_ACC, a);
      rd(REG_STAT, s);
    end
    for (int i = 0; i < 6; i++) begin
      rnd(f);
      rnd(k);
      if (i < 4) k = negs[i];
      r = ~k + 8'h01;
      wmem({4'h5, f}, k);
      exe(1'b1, {ENC_NEG, 1'b1, f}, '0);
      rmem({4'h5, f}, r);
      rd(REG_STAT, {3'h0, r[7], k == 8'h80, r == 8'h00, k[3:0] == 4'h0, k == 8'h00});
    end
    // indexed edge at 5f and 60
    wr(REG_CTRL, 8'h01);
    wr(REG_IDXL, 8'h34);
    wr(REG_IDXH, 8'h02);
    wmem(12'h293, 8'h3A);
    exe(1'b1, {ENC_NEG, 1'b0, 8'h5F}, '0);
    rmem(12'h293, 8'hC6);
    wmem(12'hF60, 8'h11);
    exe(1'b1, {ENC_NEG, 1'b0, 8'h60}, '0);
    rmem(12'hF60, 8'hEF);
    wr(REG_CTRL, 8'h00);
    exe(1'b1, ENC_PUSH, 21'h00_0124);
    rd(REG_SPTR, 8'h01);
    rd(REG_TOSL, 8'h26);
    rd(REG_TOSH, 8'h01);
    wr(REG_TOSL, 8'h5A);
    wr(REG_TOSH, 8'h34);
    exe(1'b1, ENC_PUSH, 21'h01_0200);
    rd(REG_SPTR, 8'h02);
    rd(REG_TOSU, 8'h01);
    rd(REG_TOSL, 8'h02);
    exe(1'b1, ENC_POP, 21'h00_0300);
    rd(REG_SPTR, 8'h01);
    rd(REG_TOSL, 8'h5A);
    rd(REG_TOSH, 8'h34);
    wr(REG_ACC, 8'h5A);
    wr(REG_STAT, 8'h0A);
    for (int i = 0; i < 3; i++) begin
      rnd(k);
      exe(i != 2, (i == 0) ? 16'h0000 : {4'hF, k[3:0], k}, 21'h00_0400);
      rd(REG_SPTR, 8'h01);
      rd(REG_ACC, 8'h5A);
      rd(REG_STAT, 8'h0A);
      rd(REG_PLO, prod[7:0]);
    end
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
